// file: hw/hcd_desc.sv
module hcd_desc (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        req_i,
    input  wire logic        req_other_i,
    input  wire logic [15:0] req_len_i,
    input  wire logic        high_speed_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic       [7:0] data_o,
    output logic             last_o,
    output logic             busy_o
);
    import hcd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hcd_state_e       state;
    hcd_state_e       next_state;
    logic       [4:0] index;
    logic       [4:0] count;
    logic             other;
    logic             speed;

    wire logic [7:0]  rom_byte;
    wire logic        start;
    wire logic        take;
    wire logic        final_beat;
    wire logic [4:0]  clip_len;
    wire logic [4:0]  next_index;

    // truncate to the smaller of request and descriptor set
    assign clip_len   = (req_len_i > 16'(HCD_TOTAL_LEN)) ? 5'(HCD_TOTAL_LEN)
                                                        : req_len_i[4:0];
    assign start      = (state == HCD_IDLE) && req_i && (req_len_i != 16'h0000);
    assign take       = valid_o && ready_i;
    assign final_beat = (index + 5'd1 == count);
    assign next_index = start ? 5'd0 : (take ? index + 5'd1 : index);

    hcd_rom u_rom (
        .index_i       (next_index),
        .high_speed_i  (start ? high_speed_i : speed),
        .other_speed_i (start ? req_other_i : other),
        .byte_o        (rom_byte)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            HCD_IDLE: begin
                if (start) begin
                    next_state = HCD_SEND;
                end
            end
            HCD_SEND: begin
                if (take && final_beat) begin
                    next_state = HCD_DONE;
                end
            end
            HCD_DONE: begin
                next_state = HCD_IDLE;
            end
            default: begin
                next_state = HCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= HCD_IDLE;
            index <= 5'd0;
            count <= 5'd0;
            other <= 1'b0;
            speed <= 1'b0;
        end else begin
            state <= next_state;
            index <= next_index;
            if (start) begin
                count <= clip_len;
                other <= req_other_i;
                speed <= high_speed_i;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            valid_o <= 1'b0;
            data_o  <= 8'h00;
            last_o  <= 1'b0;
            busy_o  <= 1'b0;
        end else begin
            busy_o <= (next_state != HCD_IDLE);
            if (start) begin
                valid_o <= 1'b1;
                data_o  <= rom_byte;
                last_o  <= (clip_len == 5'd1);
            end else if (take) begin
                valid_o <= !final_beat;
                data_o  <= final_beat ? 8'h00 : rom_byte;
                last_o  <= (index + 5'd2 == count);
            end
        end
    end

    // ------------------------------------------------------------
    // checks: configuration descriptor
    // ------------------------------------------------------------
    // byte checks sample on the taking edge, while the byte still stands on data_o
    a_cfg_head_len: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_CFG_LEN_OFS
        |-> data_o == HCD_CFG_LEN)
        else $error("descriptor does not open with length 09");
    // the other-speed reply differs from the normal one only in this byte
    a_cfg_type_sel: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_TYPE_OFS
        |-> data_o == (other ? HCD_OSC_TYPE : HCD_CFG_TYPE))
        else $error("configuration type byte wrong");
    a_total_len_lo: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_TOTAL_LO_OFS
        |-> data_o == HCD_TOTAL_LO)
        else $error("total length low byte wrong");
    a_total_len_hi: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_TOTAL_HI_OFS
        |-> data_o == HCD_TOTAL_HI)
        else $error("total length high byte wrong");
    a_num_ifaces: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_NUM_IF_OFS
        |-> data_o == HCD_NUM_IF)
        else $error("interface count byte wrong");
    a_cfg_value: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_CFG_VALUE_OFS
        |-> data_o == HCD_CFG_VALUE)
        else $error("configuration value byte wrong");
    a_cfg_string: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_CFG_STR_OFS
        |-> data_o == HCD_CFG_STR)
        else $error("configuration string index wrong");
    a_attr_byte: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_CFG_ATTR_OFS
        |-> data_o == HCD_CFG_ATTR)
        else $error("attributes byte wrong");
    a_max_power: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_MAX_POWER_OFS
        |-> data_o == HCD_MAX_POWER)
        else $error("maximum power byte wrong");

    // ------------------------------------------------------------
    // checks: interface descriptor
    // ------------------------------------------------------------
    a_if_len: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_LEN_OFS
        |-> data_o == HCD_IF_LEN)
        else $error("interface length byte wrong");
    a_if_type: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_TYPE_OFS
        |-> data_o == HCD_IF_TYPE)
        else $error("interface type byte wrong");
    a_if_number: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_NUM_OFS
        |-> data_o == HCD_IF_NUM)
        else $error("interface number byte wrong");
    a_if_alt: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_ALT_OFS
        |-> data_o == HCD_IF_ALT)
        else $error("alternate setting byte wrong");
    a_if_num_ep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_NUM_EP_OFS
        |-> data_o == HCD_IF_NUM_EP)
        else $error("endpoint count byte wrong");
    a_if_class: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_CLASS_OFS
        |-> data_o == HCD_IF_CLASS)
        else $error("interface class byte wrong");
    a_if_subclass: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_SUB_OFS
        |-> data_o == HCD_IF_SUB)
        else $error("interface subclass byte wrong");
    a_if_proto: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_PROTO_OFS
        |-> data_o == HCD_IF_PROTO)
        else $error("interface protocol byte wrong");
    a_if_string: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IF_STR_OFS
        |-> data_o == HCD_IF_STR)
        else $error("interface string index wrong");

    // ------------------------------------------------------------
    // checks: endpoint descriptor
    // ------------------------------------------------------------
    a_ep_len: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_EP_LEN_OFS
        |-> data_o == HCD_EP_LEN)
        else $error("endpoint length byte wrong");
    a_ep_type: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_EP_TYPE_OFS
        |-> data_o == HCD_EP_TYPE)
        else $error("endpoint type byte wrong");
    a_ep_addr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_EP_ADDR_OFS
        |-> data_o == HCD_EP_ADDR)
        else $error("endpoint address wrong");
    a_ep_attr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_EP_ATTR_OFS
        |-> data_o == HCD_EP_ATTR)
        else $error("endpoint attributes byte wrong");
    a_mps_lo: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_MPS_LO_OFS
        |-> data_o == HCD_EP_MPS_LO)
        else $error("packet size low byte wrong");
    a_mps_hi: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_MPS_HI_OFS
        |-> data_o == HCD_EP_MPS_HI)
        else $error("packet size high byte wrong");
    // interval follows the speed latched at request, not the live pin
    a_poll_ival: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && index == HCD_IVAL_OFS
        |-> data_o == (speed ? HCD_IVAL_HS : HCD_IVAL_FS))
        else $error("polling interval wrong for speed");

    // ------------------------------------------------------------
    // checks: reply framing
    // ------------------------------------------------------------
    // a reply opens one cycle after the request and stops at the clipped length
    a_start_valid: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        start
        |=> valid_o && index == HCD_CFG_LEN_OFS && busy_o && data_o == HCD_CFG_LEN)
        else $error("reply did not start one cycle after request");
    a_trunc_end: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && last_o
        |-> index + 5'h01 == count ##1 !valid_o)
        else $error("reply not ended at requested length");
    a_zero_len: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        state == HCD_IDLE && req_i && req_len_i == 16'h0000
        |=> !valid_o && !busy_o)
        else $error("zero-length request produced a reply");
    a_clip_full: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        start && req_len_i > 16'(HCD_TOTAL_LEN)
        |=> count == 5'(HCD_TOTAL_LEN))
        else $error("long request not clipped to the descriptor set");
    a_clip_short: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        start && req_len_i <= 16'(HCD_TOTAL_LEN)
        |=> count == $past(req_len_i[4:0]))
        else $error("short request length not kept");

    // a refused byte must stand unchanged until the consumer takes it
    a_hold_stall: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        valid_o && !ready_i
        |=> valid_o && $stable(data_o) && $stable(last_o))
        else $error("byte changed while stalled");
    a_order_step: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && !last_o
        |=> valid_o && index == $past(index) + 5'h01)
        else $error("bytes not sent in offset order");
    a_idle_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        !valid_o
        |-> data_o == 8'h00 && !last_o)
        else $error("data or last shown without valid");
    a_last_valid: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        last_o
        |-> valid_o)
        else $error("last flag without a byte");
    a_busy_covers: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        valid_o
        |-> busy_o)
        else $error("byte offered while not busy");
    a_index_bound: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        valid_o
        |-> index < count)
        else $error("byte offered past the clipped length");

    // busy lingers one cycle after the last byte so a back-to-back request is refused
    a_done_busy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        take && last_o
        |=> busy_o ##1 !busy_o)
        else $error("busy not released one cycle after the last byte");
    // a request while busy must not disturb the reply in flight
    a_req_refused: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        busy_o && req_i
        |=> $stable(count) && $stable(other) && $stable(speed))
        else $error("request accepted while busy");
endmodule : hcd_desc

// file: hw/hcd_pkg.sv
package hcd_pkg;
    // ------------------------------------------------------------
    // descriptor layout
    // ------------------------------------------------------------
    localparam int unsigned HCD_TOTAL_LEN  = 25;
    localparam int unsigned HCD_IDX_W      = 5;
    localparam logic [4:0]  HCD_TYPE_OFS   = 5'h01;
    localparam logic [4:0]  HCD_IVAL_OFS   = 5'h18;
    localparam logic [4:0]  HCD_CFG_LEN_OFS    = 5'h00;
    localparam logic [4:0]  HCD_TOTAL_LO_OFS   = 5'h02;
    localparam logic [4:0]  HCD_TOTAL_HI_OFS   = 5'h03;
    localparam logic [4:0]  HCD_NUM_IF_OFS     = 5'h04;
    localparam logic [4:0]  HCD_CFG_VALUE_OFS  = 5'h05;
    localparam logic [4:0]  HCD_CFG_STR_OFS    = 5'h06;
    localparam logic [4:0]  HCD_CFG_ATTR_OFS   = 5'h07;
    localparam logic [4:0]  HCD_MAX_POWER_OFS  = 5'h08;
    localparam logic [4:0]  HCD_IF_LEN_OFS     = 5'h09;
    localparam logic [4:0]  HCD_IF_TYPE_OFS    = 5'h0a;
    localparam logic [4:0]  HCD_IF_NUM_OFS     = 5'h0b;
    localparam logic [4:0]  HCD_IF_ALT_OFS     = 5'h0c;
    localparam logic [4:0]  HCD_IF_NUM_EP_OFS  = 5'h0d;
    localparam logic [4:0]  HCD_IF_CLASS_OFS   = 5'h0e;
    localparam logic [4:0]  HCD_IF_SUB_OFS     = 5'h0f;
    localparam logic [4:0]  HCD_IF_PROTO_OFS   = 5'h10;
    localparam logic [4:0]  HCD_IF_STR_OFS     = 5'h11;
    localparam logic [4:0]  HCD_EP_LEN_OFS     = 5'h12;
    localparam logic [4:0]  HCD_EP_TYPE_OFS    = 5'h13;
    localparam logic [4:0]  HCD_EP_ADDR_OFS    = 5'h14;
    localparam logic [4:0]  HCD_EP_ATTR_OFS    = 5'h15;
    localparam logic [4:0]  HCD_MPS_LO_OFS     = 5'h16;
    localparam logic [4:0]  HCD_MPS_HI_OFS     = 5'h17;
    localparam logic [7:0]  HCD_CFG_LEN    = 8'h09;
    localparam logic [7:0]  HCD_CFG_TYPE   = 8'h02;
    localparam logic [7:0]  HCD_OSC_TYPE   = 8'h07;
    localparam logic [7:0]  HCD_TOTAL_LO   = 8'h19;
    localparam logic [7:0]  HCD_TOTAL_HI   = 8'h00;
    localparam logic [7:0]  HCD_NUM_IF     = 8'h01;
    localparam logic [7:0]  HCD_CFG_VALUE  = 8'h01;
    localparam logic [7:0]  HCD_CFG_STR    = 8'h00;
    localparam logic [7:0]  HCD_CFG_ATTR   = 8'he0;
    localparam logic [7:0]  HCD_MAX_POWER  = 8'h00;
    localparam logic [7:0]  HCD_IF_LEN     = 8'h09;
    localparam logic [7:0]  HCD_IF_TYPE    = 8'h04;
    localparam logic [7:0]  HCD_IF_NUM     = 8'h00;
    localparam logic [7:0]  HCD_IF_ALT     = 8'h00;
    localparam logic [7:0]  HCD_IF_NUM_EP  = 8'h01;
    localparam logic [7:0]  HCD_IF_CLASS   = 8'h09;
    localparam logic [7:0]  HCD_IF_SUB     = 8'h00;
    localparam logic [7:0]  HCD_IF_PROTO   = 8'h00;
    localparam logic [7:0]  HCD_IF_STR     = 8'h00;
    localparam logic [7:0]  HCD_EP_LEN     = 8'h07;
    localparam logic [7:0]  HCD_EP_TYPE    = 8'h05;
    localparam logic [7:0]  HCD_EP_ADDR    = 8'h81;
    localparam logic [7:0]  HCD_EP_ATTR    = 8'h03;
    localparam logic [7:0]  HCD_EP_MPS_LO  = 8'h01;
    localparam logic [7:0]  HCD_EP_MPS_HI  = 8'h00;
    localparam logic [7:0]  HCD_IVAL_FS    = 8'hff;
    localparam logic [7:0]  HCD_IVAL_HS    = 8'h0c;

    typedef enum logic [2:0] {
        HCD_IDLE = 3'b001,
        HCD_SEND = 3'b010,
        HCD_DONE = 3'b100
    } hcd_state_e;
endpackage : hcd_pkg

// file: hw/hcd_rom.sv
module hcd_rom (
    input  wire logic [4:0] index_i,
    input  wire logic       high_speed_i,
    input  wire logic       other_speed_i,
    output logic      [7:0] byte_o
);
    import hcd_pkg::*;

    // ------------------------------------------------------------
    // table, the two speed-dependent bytes patched by the selects
    // ------------------------------------------------------------
    wire logic [7:0] rom [0:24];
    wire logic [7:0] ival;
    wire logic [7:0] ctype;

    assign ival  = high_speed_i ? HCD_IVAL_HS : HCD_IVAL_FS;
    assign ctype = other_speed_i ? HCD_OSC_TYPE : HCD_CFG_TYPE;

    assign rom[0]  = HCD_CFG_LEN;
    assign rom[1]  = ctype;
    assign rom[2]  = HCD_TOTAL_LO;
    assign rom[3]  = HCD_TOTAL_HI;
    assign rom[4]  = HCD_NUM_IF;
    assign rom[5]  = HCD_CFG_VALUE;
    assign rom[6]  = HCD_CFG_STR;
    assign rom[7]  = HCD_CFG_ATTR;
    assign rom[8]  = HCD_MAX_POWER;
    assign rom[9]  = HCD_IF_LEN;
    assign rom[10] = HCD_IF_TYPE;
    assign rom[11] = HCD_IF_NUM;
    assign rom[12] = HCD_IF_ALT;
    assign rom[13] = HCD_IF_NUM_EP;
    assign rom[14] = HCD_IF_CLASS;
    assign rom[15] = HCD_IF_SUB;
    assign rom[16] = HCD_IF_PROTO;
    assign rom[17] = HCD_IF_STR;
    assign rom[18] = HCD_EP_LEN;
    assign rom[19] = HCD_EP_TYPE;
    assign rom[20] = HCD_EP_ADDR;
    assign rom[21] = HCD_EP_ATTR;
    assign rom[22] = HCD_EP_MPS_LO;
    assign rom[23] = HCD_EP_MPS_HI;
    assign rom[24] = ival;

    assign byte_o = (index_i < 5'd25) ? rom[index_i] : 8'h00;
endmodule : hcd_rom

// file: verif/hcd_host_model.sv
module hcd_host_model (
    input  wire logic       mclk_i,
    input  wire logic       slow_i,
    input  wire logic       clr_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic       last_i,
    output logic            ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [0:31];
    int         n;
    int         last_at;
    // slow mode drops ready on every other cycle, so bytes must stand across a stall
    always @(negedge mclk_i) begin
        ready_o <= !(slow_i && ready_o === 1'b1);
    end
    always @(posedge mclk_i) begin
        if (clr_i) begin
            n       <= 0;
            last_at <= -1;
        end else if (valid_i === 1'b1 && ready_o) begin
            got[n] <= data_i;
            n      <= n + 1;
            if (last_i === 1'b1) last_at <= n;
        end
    end
endmodule : hcd_host_model

// file: verif/hcd_desc_test.sv
module hcd_desc_test;
    timeunit 1ns;
    timeprecision 1ns;
    import hcd_pkg::*;
    logic        mclk_i = 0, reset_n_i = 0, req_i = 0, req_other_i = 0, high_speed_i = 0;
    logic [15:0] req_len_i = 16'h0000;
    logic        slow = 0, clr = 1;
    logic        ready_i, valid_o, last_o, busy_o;
    logic [7:0]  data_o;
    int          err_count = 0, checks_done = 0;
    logic [7:0]  tbl [0:24] = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 8'he0, 8'h00,
        8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
        8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hff};

    hcd_desc i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_i),
        .req_other_i(req_other_i), .req_len_i(req_len_i), .high_speed_i(high_speed_i),
        .ready_i(ready_i), .valid_o(valid_o), .data_o(data_o), .last_o(last_o),
        .busy_o(busy_o));
    hcd_host_model i_host (.mclk_i(mclk_i), .slow_i(slow), .clr_i(clr), .valid_i(valid_o),
        .data_i(data_o), .last_i(last_o), .ready_o(ready_i));

    always #20 mclk_i = ~mclk_i;

    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic check_int(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : check_int

    function automatic logic [7:0] expect_at(input int k, input logic other, input logic hs);
        if (k == 1 && other) return 8'h07;
        if (k == 24) return hs ? 8'h0c : 8'hff;
        return tbl[k];
    endfunction : expect_at

    // speed is flipped after the taking edge: the reply must keep the latched one
    task automatic run_req(input logic [15:0] len, input logic other, input logic hs,
                           input logic poke);
        int want;
        int k;
        @(negedge mclk_i);
        clr = 1;
        @(negedge mclk_i);
        clr = 0;
        req_i = 1;
        req_len_i = len;
        req_other_i = other;
        high_speed_i = hs;
        @(negedge mclk_i);
        check_byte({7'h00, busy_o}, (len != 16'h0000) ? 8'h01 : 8'h00, "busy");
        check_byte(data_o, (len != 16'h0000) ? HCD_CFG_LEN : 8'h00, "first byte");
        req_i = poke;
        req_len_i = 16'h0002;
        req_other_i = ~other;
        high_speed_i = ~hs;
        repeat (2) @(negedge mclk_i);
        req_i = 0;
        for (k = 0; k < 200 && busy_o !== 1'b0; k++) @(negedge mclk_i);
        if (k == 200) begin
            err_count++;
            $display("wrong value at %0t: reply never ended", $time);
            test_done();
        end
        want = (len > 25) ? 25 : len;
        check_int(i_host.n, want, "byte count");
        if (want > 0) check_int(i_host.last_at, want - 1, "last flag");
        for (k = 0; k < want; k++) begin
            check_byte(i_host.got[k], expect_at(k, other, hs), "byte");
        end
        check_byte({7'h00, valid_o}, 8'h00, "idle valid");
        check_byte(data_o, 8'h00, "idle data");
    endtask : run_req

    task automatic test_full_fs;
        slow = 0;
        run_req(16'd25, 1'b0, 1'b0, 1'b0);
    endtask : test_full_fs

    task automatic test_other_hs_stall;
        slow = 1;
        run_req(16'd25, 1'b1, 1'b1, 1'b1);
        slow = 0;
    endtask : test_other_hs_stall

    task automatic test_truncate;
        run_req(16'd2, 1'b0, 1'b1, 1'b0);
        run_req(16'd300, 1'b0, 1'b1, 1'b0);
        run_req(16'd24, 1'b1, 1'b0, 1'b0);
        run_req(16'd0, 1'b0, 1'b0, 1'b0);
    endtask : test_truncate

    initial begin
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_n_i = 1;
        test_full_fs();
        test_other_hs_stall();
        test_truncate();
        test_done();
    end
endmodule : hcd_desc_test
